/* gpc_regs.svh */
// Register offsets, pin width, reset values and timing for the pad configuration block
// Assumes byte addressing on a 32-bit AXI4-Lite slave, one register per aligned word
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH
`define GPC_OFF_TWO_MA_BIT      12'h500
`define GPC_OFF_FOUR_MA_BIT      12'h504
`define GPC_OFF_EIGHT_MA_BIT      12'h508
`define GPC_OFF_ODR       12'h50C
`define GPC_OFF_PUR       12'h510
`define GPC_OFF_PDR       12'h514
`define GPC_OFF_DIR       12'h518
`define GPC_PIN_W         8
`define GPC_RST_TWO_MA_BIT      8'hFF
`define GPC_RST_FOUR_MA_BIT      8'h00
`define GPC_RST_EIGHT_MA_BIT      8'h00
`define GPC_RST_ODR       8'h00
`define GPC_RST_PUR       8'hFF
`define GPC_RST_PDR       8'h00
`define GPC_RST_DIR       8'h00
`define GPC_RESP_OKAY     2'h0
`define GPC_RESP_SLVERR   2'h2
`define GPC_XCLR_DELAY_NS 10
`define GPC_CLK_NS        5
`define GPC_XCLR_CYC      (`GPC_XCLR_DELAY_NS / `GPC_CLK_NS)
`endif

/* gpc_pkg.sv */
// Types for the pad configuration block
// Assumes gpc_regs.svh supplies the widths
`include "gpc_regs.svh"
package gpc_pkg;
  typedef logic [`GPC_PIN_W-1:0] gpc_pins_t;
  typedef enum logic [1:0] {
    GPC_IDLE = 2'h0,
    GPC_RESP = 2'h1
  } gpc_bstate_t;
  typedef struct packed {
    gpc_pins_t   two_ma_bit;
    gpc_pins_t   four_ma_bit;
    gpc_pins_t   eight_ma_bit;
    gpc_pins_t   odr;
    gpc_pins_t   pur;
    gpc_pins_t   pdr;
    gpc_pins_t   dir;
    gpc_pins_t   clr2;
    gpc_pins_t   clr4;
    gpc_pins_t   clr8;
    logic        aw_hold;
    logic [11:0] aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    gpc_bstate_t wst;
    logic [1:0]  bresp;
    gpc_bstate_t rst_s;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    gpc_pins_t   pad_oe_dis;
    gpc_pins_t   pad_od;
    gpc_pins_t   pad_pu;
    gpc_pins_t   pad_pd;
  } gpc_state_t;
endpackage : gpc_pkg

/* gpc_pad_cfg.sv */
// AXI4-Lite register block holding per-pin pad configuration of an 8-pin port
// Assumes one clock, synchronous active-low reset, software as the only writer
`timescale 1ns/1ps
`include "gpc_regs.svh"
module gpc_pad_cfg
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  // Write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // Write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // Read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  // Read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Pad controls
  output gpc_pins_t        pad_drive_two_ma,
  output gpc_pins_t        pad_drive_four_ma,
  output gpc_pins_t        pad_drive_eight_ma,
  output gpc_pins_t        pad_open_drain,
  output gpc_pins_t        pad_open_drain_in_only,
  output gpc_pins_t        pad_pull_up,
  output gpc_pins_t        pad_pull_down
);

  gpc_state_t st_reg;
  gpc_state_t st_next;

  logic       wr_fire;
  logic       wr_ok;
  gpc_pins_t  wbits;
  logic [31:0] rd_word;
  logic       rd_ok;

  always_comb
  begin
    st_next = st_reg;
    wr_fire = st_reg.aw_hold && st_reg.w_hold && (st_reg.wst == GPC_IDLE);
    wbits   = st_reg.w_strb[0] ? st_reg.w_data[7:0] : 8'h00;
    wr_ok   = 1'b1;
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;

    // Pending cross-clears land one cycle after the write itself
    // Second-cycle cross-clear
    st_next.two_ma_bit = st_reg.two_ma_bit & ~st_reg.clr2;
    st_next.four_ma_bit = st_reg.four_ma_bit & ~st_reg.clr4;
    st_next.eight_ma_bit = st_reg.eight_ma_bit & ~st_reg.clr8;
    st_next.clr2 = 8'h00;
    st_next.clr4 = 8'h00;
    st_next.clr8 = 8'h00;

    if (s_axi_awvalid && !st_reg.aw_hold)
    begin
      st_next.aw_hold = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_hold)
    begin
      st_next.w_hold = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    if (wr_fire)
    begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold  = 1'b0;
      case (st_reg.aw_addr)
        `GPC_OFF_TWO_MA_BIT:
        begin
          if (st_reg.w_strb[0])
          begin
            st_next.two_ma_bit = wbits;
            st_next.clr4 = wbits;
            st_next.clr8 = wbits;
          end
        end
        `GPC_OFF_FOUR_MA_BIT:
        begin
          if (st_reg.w_strb[0])
          begin
            st_next.four_ma_bit = wbits;
            st_next.clr2 = wbits;
            st_next.clr8 = wbits;
          end
        end
        `GPC_OFF_EIGHT_MA_BIT:
        begin
          if (st_reg.w_strb[0])
          begin
            st_next.eight_ma_bit = wbits;
            st_next.clr2 = wbits;
            st_next.clr4 = wbits;
          end
        end
        `GPC_OFF_ODR:
        begin
          if (st_reg.w_strb[0])
            st_next.odr = wbits;
        end
        `GPC_OFF_PUR:
        begin
          if (st_reg.w_strb[0])
          begin
            st_next.pur = wbits;
            st_next.pdr = st_reg.pdr & ~wbits;
          end
        end
        `GPC_OFF_PDR:
        begin
          if (st_reg.w_strb[0])
          begin
            st_next.pdr = wbits;
            st_next.pur = st_reg.pur & ~wbits;
          end
        end
        `GPC_OFF_DIR:
        begin
          if (st_reg.w_strb[0])
            st_next.dir = wbits;
        end
        default: wr_ok = 1'b0;
      endcase
      st_next.wst   = GPC_RESP;
      st_next.bresp = wr_ok ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
    end
    else if (st_reg.wst == GPC_RESP && s_axi_bready)
      st_next.wst = GPC_IDLE;

    case (s_axi_araddr)
      `GPC_OFF_TWO_MA_BIT: rd_word = {24'h000000, st_reg.two_ma_bit};
      `GPC_OFF_FOUR_MA_BIT: rd_word = {24'h000000, st_reg.four_ma_bit};
      `GPC_OFF_EIGHT_MA_BIT: rd_word = {24'h000000, st_reg.eight_ma_bit};
      `GPC_OFF_ODR:  rd_word = {24'h000000, st_reg.odr};
      `GPC_OFF_PUR:  rd_word = {24'h000000, st_reg.pur};
      `GPC_OFF_PDR:  rd_word = {24'h000000, st_reg.pdr};
      `GPC_OFF_DIR:  rd_word = {24'h000000, st_reg.dir};
      default:       rd_ok   = 1'b0;
    endcase
    case (st_reg.rst_s)
      GPC_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          st_next.rst_s = GPC_RESP;
          st_next.rdata = rd_word;
          st_next.rresp = rd_ok ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
        end
      end
      GPC_RESP:
      begin
        if (s_axi_rready)
          st_next.rst_s = GPC_IDLE;
      end
      default: st_next.rst_s = GPC_IDLE;
    endcase

    st_next.pad_od     = st_next.odr;
    // Open drain input when direction is zero
    st_next.pad_oe_dis = st_next.odr & ~st_next.dir;
    st_next.pad_pu     = st_next.pur;
    st_next.pad_pd     = st_next.pdr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg            <= '0;
      st_reg.two_ma_bit       <= `GPC_RST_TWO_MA_BIT;
      st_reg.four_ma_bit       <= `GPC_RST_FOUR_MA_BIT;
      st_reg.eight_ma_bit       <= `GPC_RST_EIGHT_MA_BIT;
      st_reg.odr        <= `GPC_RST_ODR;
      st_reg.pur        <= `GPC_RST_PUR;
      st_reg.pdr        <= `GPC_RST_PDR;
      st_reg.dir        <= `GPC_RST_DIR;
      st_reg.pad_pu     <= `GPC_RST_PUR;
      st_reg.wst        <= GPC_IDLE;
      st_reg.rst_s      <= GPC_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // Write ready flags are the hold flags inverted and arready decodes the read state, so they stay flop-driven
  assign s_axi_awready          = ~st_reg.aw_hold;
  assign s_axi_wready           = ~st_reg.w_hold;
  assign s_axi_bvalid           = (st_reg.wst == GPC_RESP);
  assign s_axi_bresp            = st_reg.bresp;
  assign s_axi_arready          = (st_reg.rst_s == GPC_IDLE);
  assign s_axi_rvalid           = (st_reg.rst_s == GPC_RESP);
  assign s_axi_rdata            = st_reg.rdata;
  assign s_axi_rresp            = st_reg.rresp;
  assign pad_drive_two_ma       = st_reg.two_ma_bit;
  assign pad_drive_four_ma      = st_reg.four_ma_bit;
  assign pad_drive_eight_ma     = st_reg.eight_ma_bit;
  assign pad_open_drain         = st_reg.pad_od;
  assign pad_open_drain_in_only = st_reg.pad_oe_dis;
  assign pad_pull_up            = st_reg.pad_pu;
  assign pad_pull_down          = st_reg.pad_pd;

  logic wr_four_ma_bit_set;
  assign wr_four_ma_bit_set = wr_fire && st_reg.aw_addr == `GPC_OFF_FOUR_MA_BIT && st_reg.w_strb[0];

  sequence s_four_ma_bit_write;
    wr_four_ma_bit_set ##0 (st_reg.w_data[0] == 1'b1);
  endsequence

  // Pins raised by the write that executes this cycle, one mask per drive register
  // Masks are zero outside that cycle, so properties can key on them directly
  gpc_pins_t set_two;
  gpc_pins_t set_four;
  gpc_pins_t set_eight;
  assign set_two   = (wr_fire && st_reg.aw_addr == `GPC_OFF_TWO_MA_BIT) ? wbits : 8'h00;
  assign set_four  = (wr_fire && st_reg.aw_addr == `GPC_OFF_FOUR_MA_BIT) ? wbits : 8'h00;
  assign set_eight = (wr_fire && st_reg.aw_addr == `GPC_OFF_EIGHT_MA_BIT) ? wbits : 8'h00;

  sequence s_two_write;
    set_two != 8'h00;
  endsequence

  sequence s_four_write;
    set_four != 8'h00;
  endsequence

  sequence s_eight_write;
    set_eight != 8'h00;
  endsequence

  sequence s_open_drain_write;
    wr_fire && st_reg.aw_addr == `GPC_OFF_ODR && st_reg.w_strb[0];
  endsequence

  sequence s_pull_up_write;
    wr_fire && st_reg.aw_addr == `GPC_OFF_PUR && st_reg.w_strb[0];
  endsequence

  sequence s_pull_down_write;
    wr_fire && st_reg.aw_addr == `GPC_OFF_PDR && st_reg.w_strb[0];
  endsequence

  a_two_ma_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    s_four_ma_bit_write |=> ##1 !st_reg.two_ma_bit[0])
    else $error("2mA bit not cleared after 4mA write");
  a_four_ma_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && st_reg.aw_addr == `GPC_OFF_TWO_MA_BIT && st_reg.w_strb[0] && st_reg.w_data[1])
    |=> ##1 !st_reg.four_ma_bit[1])
    else $error("4mA bit not cleared after 2mA write");
  a_eight_ma_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && st_reg.aw_addr == `GPC_OFF_FOUR_MA_BIT && st_reg.w_strb[0] && st_reg.w_data[2])
    |=> ##1 !st_reg.eight_ma_bit[2])
    else $error("8mA bit not cleared after 4mA write");
  a_clear_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_four_ma_bit_write ##0 (st_reg.two_ma_bit[0] && !st_reg.clr2[0])) |=> st_reg.two_ma_bit[0])
    else $error("Cross-clear landed too early");
  a_readback_set: assert property (@(posedge aclk) disable iff (!aresetn)
    s_four_ma_bit_write |=> st_reg.four_ma_bit[0] [*2])
    else $error("Written drive bit lost");
  a_pull_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && st_reg.aw_addr == `GPC_OFF_PUR && st_reg.w_strb[0])
    |=> ((st_reg.pur & st_reg.pdr) == 8'h00))
    else $error("Pull-up and pull-down both set");
  a_open_drain_in: assert property (@(posedge aclk) disable iff (!aresetn)
    pad_open_drain_in_only == (st_reg.odr & ~st_reg.dir))
    else $error("Open drain input mode mismatch");
  a_high_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Upper read bits not zero");

  a_two_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    s_two_write |=> ##1 (((st_reg.four_ma_bit | st_reg.eight_ma_bit) & $past(set_two, 2)) == 8'h00))
    else $error("2mA write left a 4mA or 8mA bit set");
  a_four_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    s_four_write |=> ##1 (((st_reg.two_ma_bit | st_reg.eight_ma_bit) & $past(set_four, 2)) == 8'h00))
    else $error("4mA write left a 2mA or 8mA bit set");
  a_eight_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    s_eight_write |=> ##1 (((st_reg.two_ma_bit | st_reg.four_ma_bit) & $past(set_eight, 2)) == 8'h00))
    else $error("8mA write left a 2mA or 4mA bit set");
  // One cycle after the write the other registers must still hold their old bits
  a_clear_not_early: assert property (@(posedge aclk) disable iff (!aresetn)
    s_eight_write |=> ((st_reg.two_ma_bit == $past(st_reg.two_ma_bit)) &&
                       (st_reg.four_ma_bit == $past(st_reg.four_ma_bit))))
    else $error("Cross-clear landed before the second cycle");
  a_written_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_two_write or s_four_write or s_eight_write) |=> ##1
      (((st_reg.two_ma_bit & $past(set_two, 2)) == $past(set_two, 2)) &&
       ((st_reg.four_ma_bit & $past(set_four, 2)) == $past(set_four, 2)) &&
       ((st_reg.eight_ma_bit & $past(set_eight, 2)) == $past(set_eight, 2))))
    else $error("Written drive bits not held");
  a_pull_down_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pull_down_write |=> ((st_reg.pur & st_reg.pdr) == 8'h00))
    else $error("Pull-down write left pull-up set");
  a_open_drain_pad: assert property (@(posedge aclk) disable iff (!aresetn)
    s_open_drain_write |=> (pad_open_drain == $past(wbits)))
    else $error("Open drain pads do not follow the write");
  a_pull_up_pad: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pull_up_write |=> (pad_pull_up == $past(wbits)))
    else $error("Pull-up pads do not follow the write");
  a_others_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    s_open_drain_write |=> ((st_reg.pur == $past(st_reg.pur)) &&
                            (st_reg.two_ma_bit == $past(st_reg.two_ma_bit))))
    else $error("Open drain write disturbed other registers");

endmodule : gpc_pad_cfg

/* gpio_pad_config_regs_bench.sv */
// Self-checking bench for the pad configuration register block
// Assumes an AXI4-Lite slave that answers in a few cycles and a 200 MHz clock
`timescale 1ns/1ps
`include "gpc_regs.svh"
module gpio_pad_config_regs_bench
  import gpc_pkg::*;
;
  logic        aclk, aresetn;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  gpc_pins_t   pad_drive_two_ma, pad_drive_four_ma, pad_drive_eight_ma;
  gpc_pins_t   pad_open_drain, pad_open_drain_in_only, pad_pull_up, pad_pull_down;
  int          num_errors = 0;
  int          checks_done = 0;
  logic [23:0] drv_seen;

  gpc_pad_cfg dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .pad_drive_two_ma, .pad_drive_four_ma, .pad_drive_eight_ma, .pad_open_drain,
    .pad_open_drain_in_only, .pad_pull_up, .pad_pull_down
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ready is sampled mid-cycle, so the release lands right after the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic       ta, tw, tb;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge aclk);
      ta  = s_axi_awvalid & s_axi_awready;
      tw  = s_axi_wvalid & s_axi_wready;
      tb  = s_axi_bvalid;
      rsp = s_axi_bresp;
      drv_seen = {pad_drive_two_ma, pad_drive_four_ma, pad_drive_eight_ma};
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tb)
        break;
    end
    s_axi_bready <= 1'b0;
    chk({tb, rsp}, {1'b1, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ta, tr;
    logic [33:0] got;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge aclk);
      ta  = s_axi_arvalid & s_axi_arready;
      tr  = s_axi_rvalid;
      got = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (tr)
        break;
    end
    s_axi_rready <= 1'b0;
    chk({tr, got}, {1'b1, er, ed});
  endtask : rd

  task automatic settle();
    repeat (3) @(negedge aclk);
  endtask : settle

  task automatic t_reset();
    rd(`GPC_OFF_TWO_MA_BIT, 32'h000000FF, `GPC_RESP_OKAY);
    rd(`GPC_OFF_FOUR_MA_BIT, 32'h00000000, `GPC_RESP_OKAY);
    rd(`GPC_OFF_ODR, 32'h00000000, `GPC_RESP_OKAY);
    rd(`GPC_OFF_PUR, 32'h000000FF, `GPC_RESP_OKAY);
    $display("test reset values done");
  endtask : t_reset

  // The first three writes set pins already held by other drive registers
  // The pads seen with the write response must not yet show the cross-clear
  task automatic t_drive();
    wr(`GPC_OFF_EIGHT_MA_BIT, 32'hFFFFFF0C, 4'hF, `GPC_RESP_OKAY);
    chk(drv_seen, 24'hFF000C);
    rd(`GPC_OFF_TWO_MA_BIT, 32'h000000F3, `GPC_RESP_OKAY);
    rd(`GPC_OFF_EIGHT_MA_BIT, 32'h0000000C, `GPC_RESP_OKAY);
    wr(`GPC_OFF_FOUR_MA_BIT, 32'h00000007, 4'hF, `GPC_RESP_OKAY);
    chk(drv_seen, 24'hF3070C);
    rd(`GPC_OFF_EIGHT_MA_BIT, 32'h00000008, `GPC_RESP_OKAY);
    rd(`GPC_OFF_TWO_MA_BIT, 32'h000000F0, `GPC_RESP_OKAY);
    rd(`GPC_OFF_FOUR_MA_BIT, 32'h00000007, `GPC_RESP_OKAY);
    wr(`GPC_OFF_TWO_MA_BIT, 32'h0000000A, 4'hF, `GPC_RESP_OKAY);
    rd(`GPC_OFF_FOUR_MA_BIT, 32'h00000005, `GPC_RESP_OKAY);
    rd(`GPC_OFF_EIGHT_MA_BIT, 32'h00000000, `GPC_RESP_OKAY);
    rd(`GPC_OFF_TWO_MA_BIT, 32'h0000000A, `GPC_RESP_OKAY);
    settle();
    chk({pad_drive_two_ma, pad_drive_four_ma, pad_drive_eight_ma}, 24'h0A0500);
    // Without the low byte strobe the register must stay as it was
    wr(`GPC_OFF_TWO_MA_BIT, 32'h000000FF, 4'hE, `GPC_RESP_OKAY);
    rd(`GPC_OFF_TWO_MA_BIT, 32'h0000000A, `GPC_RESP_OKAY);
    $display("test drive selects done");
  endtask : t_drive

  task automatic t_open_drain();
    wr(`GPC_OFF_DIR, 32'h0000000F, 4'hF, `GPC_RESP_OKAY);
    wr(`GPC_OFF_ODR, 32'h0000003C, 4'hF, `GPC_RESP_OKAY);
    rd(`GPC_OFF_ODR, 32'h0000003C, `GPC_RESP_OKAY);
    settle();
    chk(pad_open_drain, 8'h3C);
    chk(pad_open_drain_in_only, 8'h30);
    wr(`GPC_OFF_ODR, 32'h00000000, 4'hF, `GPC_RESP_OKAY);
    settle();
    chk(pad_open_drain, 8'h00);
    chk(pad_open_drain_in_only, 8'h00);
    $display("test open drain done");
  endtask : t_open_drain

  task automatic t_pulls();
    wr(`GPC_OFF_PDR, 32'h00000005, 4'hF, `GPC_RESP_OKAY);
    rd(`GPC_OFF_PUR, 32'h000000FA, `GPC_RESP_OKAY);
    settle();
    chk({pad_pull_up, pad_pull_down}, 16'hFA05);
    wr(`GPC_OFF_PUR, 32'h00000001, 4'hF, `GPC_RESP_OKAY);
    rd(`GPC_OFF_PDR, 32'h00000004, `GPC_RESP_OKAY);
    settle();
    chk({pad_pull_up, pad_pull_down}, 16'h0104);
    $display("test pulls done");
  endtask : t_pulls

  task automatic t_unmapped();
    wr(12'h600, 32'h00000001, 4'hF, `GPC_RESP_SLVERR);
    rd(12'h600, 32'h00000000, `GPC_RESP_SLVERR);
    rd(`GPC_OFF_TWO_MA_BIT, 32'h0000000A, `GPC_RESP_OKAY);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // The tests take well under 1500 cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_rready = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_drive();
    t_open_drain();
    t_pulls();
    t_unmapped();
    report_and_stop();
  end
endmodule : gpio_pad_config_regs_bench
